/* core/ssx_pkg.sv */
package ssx_pkg;

  // Datapath widths
  localparam int DATA_W   = 8;
  localparam int FILE_AW  = 6;
  localparam int ROM_AW   = 11;
  localparam int ROM_DW   = 14;
  localparam int PTR_BITS = 3;
  localparam int TDH_BITS = 6;
  localparam int APB_AW   = 8;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFF_CMD   = 8'h00;
  localparam logic [APB_AW-1:0] OFF_ACC   = 8'h04;
  localparam logic [APB_AW-1:0] OFF_STAT  = 8'h08;
  localparam logic [APB_AW-1:0] OFF_TPH   = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_TDH   = 8'h10;
  localparam logic [APB_AW-1:0] OFF_FADDR = 8'h14;
  localparam logic [APB_AW-1:0] OFF_FDATA = 8'h18;

  // Command word field positions
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_DEST_BIT  = 2;
  localparam int CMD_FADDR_LSB = 8;
  localparam int CMD_IMM_LSB   = 16;

  // Status word bit positions
  localparam int STAT_C_BIT  = 0;
  localparam int STAT_DC_BIT = 1;
  localparam int STAT_Z_BIT  = 2;

  // Reset values
  localparam logic [DATA_W-1:0]   ACC_RST   = 8'h00;
  localparam logic [2:0]          STAT_RST  = 3'h0;
  localparam logic [DATA_W-1:0]   TPH_RST   = 8'h00;
  localparam logic [TDH_BITS-1:0] TDH_RST   = 6'h00;
  localparam logic [FILE_AW-1:0]  FADDR_RST = 6'h00;

  // Operations carried by the command word
  typedef enum logic [1:0] {
    OP_SUB_ACC_FROM_FILE,
    OP_NIBBLE_SWAP_FILE,
    OP_SUB_ACC_FROM_IMMEDIATE,
    OP_ROM_TABLE_READ
  } ssx_op_e;

  // Execution sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_EXEC,
    ST_TB1,
    ST_TB2,
    ST_TB3
  } ssx_state_e;

  typedef struct packed {
    logic [DATA_W-1:0]  imm;
    logic [FILE_AW-1:0] faddr;
    logic               dest;
    ssx_op_e            op;
  } ssx_cmd_s;

  typedef struct packed {
    logic z;
    logic nibble_carry_flag;
    logic c;
  } ssx_flags_s;

endpackage

/* core/ssx_file_ram.sv */
`timescale 1ns/1ns
// File register array; read data is registered, so a read costs one clock
module ssx_file_ram #(
  parameter int DW = 8,
  parameter int AW = 6
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  // Write first is not needed: a write and a dependent read never share a cycle
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

/* core/ssx_core.sv */
`timescale 1ns/1ns
module ssx_core
  import ssx_pkg::*;
#(
  parameter int FILE_ADDR_W = FILE_AW
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [ROM_AW-1:0] rom_addr,
  input  wire logic [ROM_DW-1:0] rom_data
);

  // Sequencer and architectural state
  ssx_state_e              state;
  ssx_state_e              next_state;
  ssx_cmd_s                cmd;
  ssx_cmd_s                next_cmd;
  logic [DATA_W-1:0]       acc;
  logic [DATA_W-1:0]       next_acc;
  ssx_flags_s              flags;
  ssx_flags_s              next_flags;
  logic [DATA_W-1:0]       tph;
  logic [DATA_W-1:0]       next_tph;
  logic [TDH_BITS-1:0]     tdh;
  logic [TDH_BITS-1:0]     next_tdh;
  logic [FILE_ADDR_W-1:0]  faddr;
  logic [FILE_ADDR_W-1:0]  next_faddr;
  logic [ROM_AW-1:0]       next_rom_addr;
  logic                    ram_stale;
  logic                    next_ram_stale;

  // Bus answer state
  logic [31:0]             next_prdata;
  logic                    next_pready;
  logic                    next_pslverr;

  // File array port
  logic                    ram_we;
  logic [FILE_ADDR_W-1:0]  ram_addr;
  logic [DATA_W-1:0]       ram_wdata;
  logic [DATA_W-1:0]       ram_rdata;

  // Datapath intermediates
  logic                    access;
  logic                    answer;
  logic                    commit;
  logic                    mapped;
  ssx_cmd_s                new_cmd;
  logic [DATA_W-1:0]       operand;
  logic [DATA_W:0]         diff_full;
  logic [4:0]              diff_low;
  logic [DATA_W-1:0]       swapped;
  logic [DATA_W-1:0]       result;
  logic                    sub_op;

  ssx_file_ram #(
    .DW (DATA_W),
    .AW (FILE_ADDR_W)
  ) u_file_ram (
    .clk   (pclk),
    .we    (ram_we),
    .addr  (ram_addr),
    .wdata (ram_wdata),
    .rdata (ram_rdata)
  );

  // Decode of the bus phase and of the command word being written
  always_comb
  begin
    access  = psel & penable;
    answer  = access & ~pready & (state == ST_IDLE) & ~ram_stale; // Stall the bus while an instruction runs
    commit  = access & pready & ~pslverr;
    mapped  = (paddr == OFF_CMD) | (paddr == OFF_ACC) | (paddr == OFF_STAT) | (paddr == OFF_TPH)
            | (paddr == OFF_TDH) | (paddr == OFF_FADDR) | (paddr == OFF_FDATA);
    new_cmd.op    = ssx_op_e'(pwdata[CMD_OP_LSB +: 2]);
    new_cmd.dest  = pwdata[CMD_DEST_BIT];
    new_cmd.faddr = pwdata[CMD_FADDR_LSB +: FILE_ADDR_W];
    new_cmd.imm   = pwdata[CMD_IMM_LSB +: DATA_W];
  end

  // Arithmetic: two's complement subtract as operand + ~acc + 1
  always_comb
  begin
    sub_op    = (cmd.op == OP_SUB_ACC_FROM_FILE) | (cmd.op == OP_SUB_ACC_FROM_IMMEDIATE);
    operand   = (cmd.op == OP_SUB_ACC_FROM_IMMEDIATE) ? cmd.imm : ram_rdata;
    diff_full = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
    diff_low  = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
    swapped   = {operand[3:0], operand[7:4]};
    result    = sub_op ? diff_full[DATA_W-1:0] : swapped;
  end

  // Bus answers come one clock into the access phase when idle
  always_comb
  begin
    next_pready  = answer;
    next_pslverr = answer & ~mapped;
    next_prdata  = 32'h0000_0000;
    if (answer & ~pwrite)
    begin
      case (paddr)
        OFF_CMD:   next_prdata = 32'({cmd.imm, 2'h0, cmd.faddr, 5'h00, cmd.dest, cmd.op});
        OFF_ACC:   next_prdata = 32'(acc);
        OFF_STAT:  next_prdata = 32'(flags);
        OFF_TPH:   next_prdata = 32'(tph);
        OFF_TDH:   next_prdata = 32'(tdh);
        OFF_FADDR: next_prdata = 32'(faddr);
        OFF_FDATA: next_prdata = 32'(ram_rdata); // Array output tracks faddr while idle
        default:   next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Sequencer, register writes and file array steering
  always_comb
  begin
    next_state    = state;
    next_cmd      = cmd;
    next_acc      = acc;
    next_flags    = flags;
    next_tph      = tph;
    next_tdh      = tdh;
    next_faddr    = faddr;
    next_rom_addr = rom_addr;
    ram_we        = 1'b0;
    ram_addr      = faddr;
    ram_wdata     = pwdata[DATA_W-1:0];
    next_ram_stale = 1'b0; // Array output is only stale right after execute
    case (state)
      ST_IDLE:
      begin
        if (commit & pwrite)
        begin
          case (paddr)
            OFF_CMD:
            begin
              next_cmd = new_cmd;
              if (new_cmd.op == OP_ROM_TABLE_READ)
              begin
                next_rom_addr = {tph[PTR_BITS-1:0], acc};
                next_state    = ST_TB1;
              end
              else
              begin
                next_state = ST_FETCH;
              end
            end
            OFF_ACC:   next_acc   = pwdata[DATA_W-1:0];
            OFF_STAT:  next_flags = ssx_flags_s'(pwdata[2:0]);
            OFF_TPH:   next_tph   = pwdata[DATA_W-1:0];
            OFF_FADDR: next_faddr = pwdata[FILE_ADDR_W-1:0];
            OFF_FDATA: ram_we     = 1'b1;
            default:   next_state = ST_IDLE; // Table data high is read only
          endcase
        end
      end
      ST_FETCH:
      begin
        // First half of the instruction cycle reads the operand
        ram_addr   = cmd.faddr;
        next_state = ST_EXEC;
      end
      ST_EXEC:
      begin
        ram_addr   = cmd.faddr;
        ram_wdata  = result;
        next_state = ST_IDLE;
        // The read launched here used the instruction's address, so hold answers one clock
        next_ram_stale = 1'b1;
        if ((cmd.op != OP_SUB_ACC_FROM_IMMEDIATE) & cmd.dest)
        begin
          ram_we = 1'b1;
        end
        else
        begin
          next_acc = result;
        end
        if (sub_op)
        begin
          next_flags.c                 = diff_full[DATA_W];
          next_flags.nibble_carry_flag = diff_low[4];
          next_flags.z                 = (diff_full[DATA_W-1:0] == 8'h00);
        end
      end
      ST_TB1:
      begin
        next_state = ST_TB2;
      end
      ST_TB2:
      begin
        next_state = ST_TB3;
      end
      ST_TB3:
      begin
        // Second instruction cycle ends: ROM word is loaded, flags left alone
        next_acc   = rom_data[DATA_W-1:0];
        next_tdh   = rom_data[ROM_DW-1:DATA_W];
        next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // All state registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state    <= ST_IDLE;
      cmd      <= '0;
      acc      <= ACC_RST;
      flags    <= ssx_flags_s'(STAT_RST);
      tph      <= TPH_RST;
      tdh      <= TDH_RST;
      faddr    <= FADDR_RST;
      rom_addr <= '0;
      prdata   <= 32'h0000_0000;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      ram_stale <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      cmd      <= next_cmd;
      acc      <= next_acc;
      flags    <= next_flags;
      tph      <= next_tph;
      tdh      <= next_tdh;
      faddr    <= next_faddr;
      rom_addr <= next_rom_addr;
      prdata   <= next_prdata;
      pready   <= next_pready;
      pslverr  <= next_pslverr;
      ram_stale <= next_ram_stale;
    end
  end

endmodule

/* verification/ssx_core_chk.sv */
`timescale 1ns/1ns
// Watches the APB answers and the ROM address of the core
module ssx_core_chk
  import ssx_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic [ROM_DW-1:0] rom_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A write that commits into the given register
  sequence s_wr(logic [APB_AW-1:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  // Mapped means aligned and not past the last register
  logic bad;
  assign bad = paddr > OFF_FDATA || paddr[1:0] != 2'b00;
  // Shadow of what software last wrote; acc_ok drops once a command may have changed the accumulator
  logic [7:0] acc_sh;
  logic [2:0] tph_sh;
  logic       acc_ok;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_sh <= ACC_RST;
      tph_sh <= TPH_RST[2:0];
      acc_ok <= 1'b1;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == OFF_ACC)
      begin
        acc_sh <= pwdata[7:0];
        acc_ok <= 1'b1;
      end
      if (paddr == OFF_TPH)
      begin
        tph_sh <= pwdata[2:0];
      end
      if (paddr == OFF_CMD)
      begin
        acc_ok <= 1'b0;
      end
    end
  end
  // A table read command that commits
  sequence s_table_go;
    s_wr(OFF_CMD) ##0 pwdata[1:0] == 2'd3;
  endsequence
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_unmapped: assert property (pready && bad |-> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (pslverr |-> pready && bad)
    else $error("spurious pslverr");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  // Busy window: pready stays low four cycles after the command, for ALU ops and for the table read alike
  a_alu_busy: assert property (s_wr(OFF_CMD) ##0 pwdata[1:0] != 2'd3 |=> !pready [*4])
    else $error("ALU op finished early");
  a_table_busy: assert property (s_wr(OFF_CMD) ##0 pwdata[1:0] == 2'd3 |=> !pready [*4])
    else $error("table read finished early");
  a_rom_low: assert property (s_table_go ##0 acc_ok |=> rom_addr[7:0] == acc_sh)
    else $error("ROM address low byte wrong");
  a_rom_high: assert property (s_table_go |=> rom_addr[10:8] == tph_sh)
    else $error("ROM address high bits wrong");
endmodule
bind ssx_core ssx_core_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rom_addr(rom_addr), .rom_data(rom_data));

/* verification/ssx_core_tb.sv */
`timescale 1ns/1ns
// Bench drives APB itself and stands in for the program ROM
module ssx_core_tb
  import ssx_pkg::*;
;
  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, tq;
  logic              pready, pslverr, te;
  logic [ROM_AW-1:0] rom_addr;
  logic [ROM_DW-1:0] rom_data;
  int                n_fail = 0, cmp_count = 0;
  always #5 pclk = ~pclk;
  // ROM contents: one fixed word, the rest a scramble of the address
  function automatic logic [ROM_DW-1:0] rom_word(input logic [ROM_AW-1:0] x);
    return (x == 11'h234) ? 14'h35aa : {x[10:5] ^ 6'h2a, x[7:0] ^ 8'hc3};
  endfunction
  assign rom_data = rom_word(rom_addr);
  ssx_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rom_addr(rom_addr), .rom_data(rom_data));
  task automatic wrap_up();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One transfer; pready and the answer are taken at the rising edge where pready stands high
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40)
    begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1) n_fail++;
    tq = prdata;
    te = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never assigns psel twice in a time step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(tq, exp);
  endtask
  // Reset values, unmapped places and the read-only high data register
  task automatic t_refuse();
    rd(OFF_ACC, 32'h0);
    rd(OFF_STAT, 32'h0);
    rd(OFF_TPH, 32'h0);
    rd(OFF_FADDR, 32'h0);
    wr(8'h1c, 32'hff);
    chk({31'h0, te}, 32'h1);
    rd(8'h05, 32'h0);
    chk({31'h0, te}, 32'h1);
    wr(OFF_TDH, 32'h3f);
    rd(OFF_TDH, 32'h0);
  endtask
  // Runs one ALU op; status is preset so untouched and updated flags differ
  task automatic run_op(input logic [1:0] op, input logic [5:0] fa, input logic [7:0] r, a, i, input logic d);
    logic [7:0] s, y;
    logic [2:0] f, p;
    logic       to_file;
    s = (op == 2'd2) ? i : r;
    y = (op == 2'd1) ? {r[3:0], r[7:4]} : s - a;
    f = {y == 8'h00, s[3:0] >= a[3:0], s >= a};
    p = (op == 2'd1) ? 3'h5 : ~f;
    to_file = d && op != 2'd2;
    wr(OFF_FADDR, {26'h0, fa});
    wr(OFF_FDATA, {24'h0, r});
    wr(OFF_ACC, {24'h0, a});
    wr(OFF_STAT, {29'h0, p});
    wr(OFF_CMD, {8'h00, i, 2'b00, fa, 5'h00, d, op});
    rd(OFF_FDATA, {24'h0, to_file ? y : r});
    rd(OFF_ACC, {24'h0, to_file ? a : y});
    rd(OFF_STAT, {29'h0, op == 2'd1 ? p : f});
  endtask
  // File subtraction at borrow, no borrow, nibble borrow and zero; immediate at borrow, no borrow and zero
  task automatic t_sub();
    run_op(2'd0, 6'd63, 8'h05, 8'h06, 8'h00, 1'b1);
    run_op(2'd0, 6'd0, 8'h06, 8'h05, 8'h00, 1'b1);
    run_op(2'd0, 6'd17, 8'h30, 8'h01, 8'h00, 1'b0);
    run_op(2'd0, 6'd9, 8'h5a, 8'h5a, 8'h00, 1'b0);
    run_op(2'd2, 6'd3, 8'h77, 8'h06, 8'h05, 1'b1);
    run_op(2'd2, 6'd4, 8'h11, 8'h05, 8'h06, 1'b0);
    run_op(2'd2, 6'd5, 8'h22, 8'hff, 8'hff, 1'b0);
  endtask
  task automatic t_swap();
    run_op(2'd1, 6'd40, 8'ha5, 8'h3c, 8'h00, 1'b1);
    run_op(2'd1, 6'd41, 8'h1e, 8'h3c, 8'h00, 1'b0);
  endtask
  // Table read; pointer bits above bit 2 must not reach the address
  task automatic t_table(input logic [7:0] tp, a);
    logic [13:0] w;
    w = rom_word({tp[2:0], a});
    wr(OFF_TPH, {24'h0, tp});
    wr(OFF_ACC, {24'h0, a});
    wr(OFF_STAT, 32'h6);
    wr(OFF_CMD, 32'h3);
    rd(OFF_ACC, {24'h0, w[7:0]});
    rd(OFF_TDH, {26'h0, w[13:8]});
    rd(OFF_STAT, 32'h6);
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_refuse();
    t_sub();
    t_swap();
    t_table(8'hfa, 8'h34);
    t_table(8'h07, 8'hff);
    wrap_up();
  end
  // Watchdog: the sequence needs well under two thousand cycles
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end
endmodule
